// File: rtl/eepwp_device.sv
`timescale 1ns/1ns
// Functional notes
// - soft flags guard lower half; pin guards all
// - permanent flag set by 0110 write, payload ignored
// - master holds protect pin low when programming flags
// - permanent flag set: 0110 control byte without high voltage unacknowledged
// - permanent flag cleared only by nv_blank, survives power loss
// - master waits write cycle after flag programming
// - reversible set 01100010, straps 0,0, high voltage
// - reversible clear 01100110, straps 0,1, high voltage
// - pin high: array access acked, nothing altered
// - pin high: flags frozen, acknowledges unchanged
// - pin low or open: flags alone decide protection
// - pin low, flag set: commit upper half only
// - pin low, flags clear: commit anywhere
// - permanent status read: no ack when set
// - reversible status read: no ack when set
// - permanent set: no ack if already set
// - reversible set: no ack if already set
// - reversible clear: no ack if permanent set
// - protected write acked, full write cycle still runs
// - strap compare on bits 3..1, bit 0 reads
module eepwp_device #(
    parameter int WR_CYCLES = eepwp_pkg::WR_LINK_CYCLES
) (
    // link
    eepwp_if.dev lnk,
    // control, synchronous to the link clock
    input wire logic reset,
    input wire logic nv_blank,
    // array write port
    output logic arr_we,
    output logic [7:0] arr_addr,
    output logic [7:0] arr_data,
    // status
    output logic permanent_lock_flag,
    output logic reversible_lock_flag,
    output logic write_busy
);
    import eepwp_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic req_m;
        logic req_s;
        // third request stage: the pins cross on flops of their own and may
        // land one edge after the toggle, so decode waits one edge longer
        logic req_d;
        logic req_seen;
        logic [4:0] pin_m;
        logic [4:0] pin_s;
        eepwp_dev_state_t state;
        logic [CNT_W-1:0] cnt;
        logic ack_tgl;
        logic acked;
        logic we;
        logic [7:0] addr;
        logic [7:0] data;
        logic perm;
        logic rev;
    } eepwp_dev_st_t;

    localparam eepwp_dev_st_t DEV_RST = '{
        req_m: 1'b0, req_s: 1'b0, req_d: 1'b0, req_seen: 1'b0,
        pin_m: PINS_ZERO, pin_s: PINS_ZERO,
        state: DEV_IDLE, cnt: CNT_ZERO,
        ack_tgl: 1'b0, acked: 1'b0, we: 1'b0,
        addr: BYTE_ZERO, data: BYTE_ZERO,
        perm: 1'b0, rev: 1'b0
    };

    eepwp_dev_st_t st_reg;
    eepwp_dev_st_t st_next;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic wp;
        logic hv;
        logic [2:0] straps;
        logic [7:0] ctrl;
        logic rd;
        logic new_req;
        logic ack;
        logic start_wr;
        wp = st_reg.pin_s[4];
        hv = st_reg.pin_s[3];
        straps = st_reg.pin_s[2:0];
        ctrl = lnk.ctrl_byte;
        rd = ctrl[0];
        new_req = st_reg.req_d != st_reg.req_seen;
        ack = 1'b0;
        start_wr = 1'b0;
        st_next = st_reg;
        st_next.req_m = lnk.req_tgl;
        st_next.req_s = st_reg.req_m;
        st_next.req_d = st_reg.req_s;
        // pins are asynchronous to the link clock: two flops first
        st_next.pin_m = {lnk.hw_protect, lnk.high_voltage_level,
                         lnk.strap_bit_2, lnk.strap_bit_1, lnk.strap_bit_0};
        st_next.pin_s = st_reg.pin_m;
        st_next.we = 1'b0;

        unique case (st_reg.state)
            DEV_BUSY: begin
                // requests here are answered without ack, as in acknowledge polling
                st_next.cnt = st_reg.cnt - CNT_ONE;
                if (st_reg.cnt == CNT_ONE) begin
                    st_next.state = DEV_IDLE;
                end
            end
            DEV_IDLE: begin
                if (new_req && ctrl[7:4] == TYPE_ARRAY && ctrl[3:1] == straps) begin
                    ack = 1'b1;
                    if (!rd) begin
                        start_wr = 1'b1;
                        // pin high blocks all; flags block the lower half
                        if (!wp && (!(st_reg.perm || st_reg.rev) || lnk.word_addr[7])) begin
                            st_next.we = 1'b1;
                            st_next.addr = lnk.word_addr;
                            st_next.data = lnk.wdata;
                        end
                    end
                end else if (new_req && ctrl[7:4] == TYPE_PROTECT && !hv
                             && ctrl[3:1] == straps && !st_reg.perm) begin
                    ack = 1'b1;
                    if (!rd) begin
                        start_wr = 1'b1;
                        // word address and data play no part here
                        if (!wp) begin
                            st_next.perm = 1'b1;
                        end
                    end
                end else if (new_req && ctrl[7:4] == TYPE_PROTECT && hv
                             && ctrl[3:1] == {straps[2:1], 1'b1}) begin
                    if (rd) begin
                        ack = !st_reg.rev;
                    end else if (ctrl[3:1] == REV_SET_SEL) begin
                        ack = !st_reg.rev;
                        start_wr = !st_reg.rev;
                        if (!st_reg.rev && !wp) begin
                            st_next.rev = 1'b1;
                        end
                    end else if (ctrl[3:1] == REV_CLR_SEL) begin
                        ack = !st_reg.perm;
                        start_wr = !st_reg.perm;
                        if (!st_reg.perm && !wp) begin
                            st_next.rev = 1'b0;
                        end
                    end
                end
                // any other straps or qualifier: no ack, flags untouched
                if (start_wr) begin
                    st_next.state = DEV_BUSY;
                    st_next.cnt = CNT_W'(WR_CYCLES);
                end
            end
        endcase

        if (new_req) begin
            st_next.req_seen = st_reg.req_d;
            st_next.ack_tgl = ~st_reg.ack_tgl;
            st_next.acked = ack;
        end

        // logic reset spares the flags; they stand for nonvolatile bits
        if (reset) begin
            st_next = DEV_RST;
            st_next.perm = st_reg.perm;
            st_next.rev = st_reg.rev;
        end
        if (nv_blank) begin
            // factory-blank state only, no command reaches this
            st_next.perm = 1'b0;
            st_next.rev = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // register
    // ------------------------------------------------------------
    always_ff @(posedge lnk.link_clk) begin
        st_reg <= st_next;
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign lnk.ack_tgl = st_reg.ack_tgl;
    assign lnk.acked = st_reg.acked;
    assign arr_we = st_reg.we;
    assign arr_addr = st_reg.addr;
    assign arr_data = st_reg.data;
    assign permanent_lock_flag = st_reg.perm;
    assign reversible_lock_flag = st_reg.rev;
    assign write_busy = st_reg.state[1];

endmodule

// File: rtl/eepwp_host.sv
`timescale 1ns/1ns
module eepwp_host #(
    parameter int HOLD_CYCLES = eepwp_pkg::WR_REF_CYCLES
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // link
    eepwp_if.host lnk,
    // user command
    input wire logic usr_start,
    input wire logic [7:0] usr_ctrl,
    input wire logic [7:0] usr_addr,
    input wire logic [7:0] usr_data,
    input wire logic usr_protect,
    input wire logic [2:0] usr_straps,
    input wire logic usr_high_voltage,
    // user answer
    output logic usr_ready,
    output logic usr_done,
    output logic usr_acked
);
    import eepwp_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] div;
        logic link_clk;
        eepwp_host_state_t state;
        logic [CNT_W-1:0] cnt;
        logic req_tgl;
        logic [7:0] ctrl;
        logic [7:0] addr;
        logic [7:0] data;
        logic wp;
        logic [2:0] straps;
        logic hv;
        logic ack_m;
        logic ack_s;
        logic ack_d;
        logic ack_seen;
        logic acked_m;
        logic acked_s;
        logic ready;
        logic done;
        logic acked;
    } eepwp_host_st_t;

    localparam eepwp_host_st_t HST_RST = '{
        div: 2'h0, link_clk: 1'b0, state: HST_IDLE, cnt: CNT_ZERO,
        req_tgl: 1'b0, ctrl: BYTE_ZERO, addr: BYTE_ZERO, data: BYTE_ZERO,
        wp: 1'b0, straps: 3'h0, hv: 1'b0,
        ack_m: 1'b0, ack_s: 1'b0, ack_d: 1'b0, ack_seen: 1'b0,
        acked_m: 1'b0, acked_s: 1'b0,
        ready: 1'b0, done: 1'b0, acked: 1'b0
    };

    eepwp_host_st_t st_reg;
    eepwp_host_st_t st_next;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        // free-running link clock from a divider
        st_next.div = st_reg.div + 2'h1;
        if (st_reg.div == LINK_HALF - 2'h1) begin
            st_next.div = 2'h0;
            st_next.link_clk = ~st_reg.link_clk;
        end
        st_next.ack_m = lnk.ack_tgl;
        st_next.ack_s = st_reg.ack_m;
        // third stage lets the answer bit settle before it is used
        st_next.ack_d = st_reg.ack_s;
        st_next.acked_m = lnk.acked;
        st_next.acked_s = st_reg.acked_m;
        st_next.done = 1'b0;

        unique case (st_reg.state)
            HST_IDLE: begin
                st_next.ready = 1'b1;
                if (usr_start) begin
                    st_next.ready = 1'b0;
                    st_next.state = HST_WAIT;
                    st_next.ctrl = usr_ctrl;
                    st_next.addr = usr_addr;
                    st_next.data = usr_data;
                    st_next.straps = usr_straps;
                    st_next.hv = usr_high_voltage;
                    // protect pin forced low while a flag is programmed
                    st_next.wp = usr_protect && !is_flag_write(usr_ctrl);
                    st_next.req_tgl = ~st_reg.req_tgl;
                end
            end
            HST_WAIT: begin
                if (st_reg.ack_d != st_reg.ack_seen) begin
                    st_next.ack_seen = st_reg.ack_d;
                    st_next.done = 1'b1;
                    st_next.acked = st_reg.acked_s;
                    if (st_reg.acked_s && !st_reg.ctrl[0]) begin
                        st_next.state = HST_HOLD;
                        st_next.cnt = CNT_W'(HOLD_CYCLES);
                    end else begin
                        st_next.state = HST_IDLE;
                        st_next.ready = 1'b1;
                    end
                end
            end
            HST_HOLD: begin
                st_next.cnt = st_reg.cnt - CNT_ONE;
                if (st_reg.cnt == CNT_ONE) begin
                    st_next.state = HST_IDLE;
                    st_next.ready = 1'b1;
                end
            end
        endcase

        if (reset) begin
            st_next = HST_RST;
        end
    end

    // ------------------------------------------------------------
    // register
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        st_reg <= st_next;
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign lnk.link_clk = st_reg.link_clk;
    assign lnk.req_tgl = st_reg.req_tgl;
    assign lnk.ctrl_byte = st_reg.ctrl;
    assign lnk.word_addr = st_reg.addr;
    assign lnk.wdata = st_reg.data;
    assign lnk.hw_protect = st_reg.wp;
    assign lnk.strap_bit_2 = st_reg.straps[2];
    assign lnk.strap_bit_1 = st_reg.straps[1];
    assign lnk.strap_bit_0 = st_reg.straps[0];
    assign lnk.high_voltage_level = st_reg.hv;
    assign usr_ready = st_reg.ready;
    assign usr_done = st_reg.done;
    assign usr_acked = st_reg.acked;

endmodule

// File: rtl/eepwp_if.sv
`timescale 1ns/1ns
interface eepwp_if;
    logic link_clk;
    logic req_tgl;
    logic [7:0] ctrl_byte;
    logic [7:0] word_addr;
    logic [7:0] wdata;
    logic hw_protect;
    logic strap_bit_2;
    logic strap_bit_1;
    logic strap_bit_0;
    logic high_voltage_level;
    logic ack_tgl;
    logic acked;

    modport dev (
        input link_clk, req_tgl, ctrl_byte, word_addr, wdata, hw_protect,
        input strap_bit_2, strap_bit_1, strap_bit_0, high_voltage_level,
        output ack_tgl, acked
    );

    modport host (
        output link_clk, req_tgl, ctrl_byte, word_addr, wdata, hw_protect,
        output strap_bit_2, strap_bit_1, strap_bit_0, high_voltage_level,
        input ack_tgl, acked
    );
endinterface

// File: rtl/eepwp_pkg.sv
package eepwp_pkg;

    // ------------------------------------------------------------
    // control byte decode
    // ------------------------------------------------------------
    localparam logic [3:0] TYPE_ARRAY = 4'hA;
    localparam logic [3:0] TYPE_PROTECT = 4'h6;
    // strap field of the reversible set and clear control bytes
    localparam logic [2:0] REV_SET_SEL = 3'h1;
    localparam logic [2:0] REV_CLR_SEL = 3'h3;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int WR_TIME_NS = 5000000;
    localparam int LINK_PERIOD_NS = 32;
    localparam int REF_PERIOD_NS = 20;
    localparam int WR_LINK_CYCLES = (WR_TIME_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
    localparam int WR_REF_CYCLES = (WR_TIME_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
    localparam int CNT_W = 18;
    localparam logic [CNT_W-1:0] CNT_ONE = 18'h00001;
    localparam logic [CNT_W-1:0] CNT_ZERO = 18'h00000;
    // ref_clk edges per half period of the generated link clock
    localparam logic [1:0] LINK_HALF = 2'h1;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [4:0] PINS_ZERO = 5'h00;

    // ------------------------------------------------------------
    // states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        DEV_IDLE = 2'b01,
        DEV_BUSY = 2'b10
    } eepwp_dev_state_t;

    typedef enum logic [2:0] {
        HST_IDLE = 3'b001,
        HST_WAIT = 3'b010,
        HST_HOLD = 3'b100
    } eepwp_host_state_t;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic is_flag_write(input logic [7:0] ctrl);
        is_flag_write = (ctrl[7:4] == TYPE_PROTECT) && !ctrl[0];
    endfunction

endpackage

// File: tb/eepwp_chk.sv
`timescale 1ns/1ns
module eepwp_chk (
    // link clock domain
    input wire logic link_clk,
    input wire logic reset,
    // link signals
    input wire logic req_tgl,
    input wire logic [7:0] ctrl_byte,
    input wire logic [7:0] word_addr,
    input wire logic [7:0] wdata,
    input wire logic hw_protect,
    input wire logic strap_bit_2,
    input wire logic strap_bit_1,
    input wire logic strap_bit_0,
    input wire logic high_voltage_level,
    input wire logic ack_tgl,
    input wire logic acked
);
    default clocking cb @(posedge link_clk); endclocking
    default disable iff (reset);
    logic pend;
    logic strap_miss;
    // never cleared: the bench blanks the flags only before the first command
    logic perm_seen_reg = 1'b0;
    assign pend = req_tgl != ack_tgl;
    assign strap_miss = ctrl_byte[3:1] != {strap_bit_2, strap_bit_1, strap_bit_0};
    always @(posedge link_clk) begin
        if ($changed(ack_tgl) && acked && ctrl_byte[7:4] == 4'h6 && !ctrl_byte[0]
            && !high_voltage_level && !hw_protect) begin
            perm_seen_reg <= 1'b1;
        end
    end
    // ------------------------------------------------------------
    // handshake
    // ------------------------------------------------------------
    ack_follow_a: assert property ($changed(req_tgl) |-> ##[1:4] $changed(ack_tgl))
        else $error("answer missing after request");
    spur_ack_a: assert property ($changed(ack_tgl) |-> $past(pend))
        else $error("answer without request");
    fields_hold_a: assert property (pend && $past(pend) |-> $stable({ctrl_byte, word_addr,
        wdata, hw_protect, strap_bit_2, strap_bit_1, strap_bit_0, high_voltage_level}))
        else $error("command fields moved while pending");
    acked_hold_a: assert property (!$changed(ack_tgl) |-> $stable(acked))
        else $error("acked moved without answer");
    // ------------------------------------------------------------
    // protection decode
    // ------------------------------------------------------------
    flag_pin_low_a: assert property (
        pend && ctrl_byte[7:4] == 4'h6 && !ctrl_byte[0] |-> !hw_protect)
        else $error("protect pin high on flag write");
    perm_noack_a: assert property (
        $changed(ack_tgl) && perm_seen_reg && ctrl_byte[7:4] == 4'h6
        && !high_voltage_level |-> !acked)
        else $error("permanent family acked after lock");
    perm_clr_noack_a: assert property (
        $changed(ack_tgl) && perm_seen_reg && ctrl_byte == 8'h66
        && high_voltage_level |-> !acked)
        else $error("reversible clear acked after lock");
    strap_miss_a: assert property (
        $changed(ack_tgl) && !high_voltage_level && strap_miss |-> !acked)
        else $error("acked with strap mismatch");
    bad_type_a: assert property (
        $changed(ack_tgl) && ctrl_byte[7:4] != 4'hA && ctrl_byte[7:4] != 4'h6 |-> !acked)
        else $error("acked unknown device type");
    array_ack_a: assert property (
        $changed(ack_tgl) && ctrl_byte[7:4] == 4'hA && !strap_miss
        && !high_voltage_level |-> acked)
        else $error("array access not acked");
endmodule

// File: tb/test_eeprom_write_protect_ctrl.sv
`timescale 1ns/1ns
module test_eeprom_write_protect_ctrl;
    import eepwp_pkg::*;
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] addr;
        logic [7:0] data;
        logic [2:0] straps;
        logic hv;
        logic prot;
        logic [3:0] exp;
    } eepwp_row_t;
    // exp is {acked, array commit, permanent flag, reversible flag}
    eepwp_row_t rows [22] = '{
        '{8'hA0, 8'h10, 8'h5A, 3'h0, 1'h0, 1'h0, 4'hC}, '{8'hA1, 8'h10, 8'h00, 3'h0, 1'h0, 1'h0, 4'h8},
        '{8'hA2, 8'h11, 8'h00, 3'h0, 1'h0, 1'h0, 4'h0}, '{8'h50, 8'h11, 8'h00, 3'h0, 1'h0, 1'h0, 4'h0},
        '{8'hA0, 8'h90, 8'h33, 3'h0, 1'h0, 1'h1, 4'h8}, '{8'h63, 8'h00, 8'h00, 3'h1, 1'h1, 1'h0, 4'h8},
        '{8'h62, 8'h00, 8'h00, 3'h3, 1'h1, 1'h0, 4'h0}, '{8'h62, 8'h00, 8'h00, 3'h1, 1'h1, 1'h1, 4'h9},
        '{8'hA0, 8'h20, 8'h44, 3'h0, 1'h0, 1'h0, 4'h9}, '{8'hA0, 8'h80, 8'h55, 3'h0, 1'h0, 1'h0, 4'hD},
        '{8'h63, 8'h00, 8'h00, 3'h1, 1'h1, 1'h0, 4'h1}, '{8'h62, 8'h00, 8'h00, 3'h1, 1'h1, 1'h0, 4'h1},
        '{8'h66, 8'h00, 8'h00, 3'h3, 1'h1, 1'h0, 4'h8}, '{8'hA0, 8'h20, 8'h66, 3'h0, 1'h0, 1'h0, 4'hC},
        '{8'h61, 8'h00, 8'h00, 3'h0, 1'h0, 1'h0, 4'h8}, '{8'h60, 8'h5A, 8'hC3, 3'h0, 1'h0, 1'h1, 4'hA},
        '{8'h61, 8'h00, 8'h00, 3'h0, 1'h0, 1'h0, 4'h2}, '{8'h60, 8'h00, 8'h00, 3'h0, 1'h0, 1'h0, 4'h2},
        '{8'h66, 8'h00, 8'h00, 3'h3, 1'h1, 1'h0, 4'h2}, '{8'hA0, 8'h7F, 8'h77, 3'h0, 1'h0, 1'h0, 4'hA},
        '{8'hA0, 8'hFF, 8'h88, 3'h0, 1'h0, 1'h0, 4'hE}, '{8'h62, 8'h00, 8'h00, 3'h1, 1'h1, 1'h0, 4'hB}
    };
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic dev_reset = 1'b1;
    logic nv_blank = 1'b1;
    logic usr_start = 1'b0;
    logic [7:0] usr_ctrl = 8'h00;
    logic [7:0] usr_addr = 8'h00;
    logic [7:0] usr_data = 8'h00;
    logic usr_protect = 1'b0;
    logic [2:0] usr_straps = 3'h0;
    logic usr_high_voltage = 1'b0;
    logic usr_ready, usr_done, usr_acked, arr_we, write_busy;
    logic permanent_lock_flag, reversible_lock_flag;
    logic [7:0] arr_addr, arr_data, we_addr, we_data;
    int miscompares = 0;
    int compares = 0;
    int we_cnt = 0;
    int cnt0;
    initial begin
        forever #10 ref_clk = ~ref_clk;
    end
    eepwp_if eepwp_if_i ();
    eepwp_host #(.HOLD_CYCLES(40)) eepwp_host_i (.ref_clk(ref_clk), .reset(reset),
        .lnk(eepwp_if_i.host), .usr_start(usr_start), .usr_ctrl(usr_ctrl), .usr_addr(usr_addr),
        .usr_data(usr_data), .usr_protect(usr_protect), .usr_straps(usr_straps),
        .usr_high_voltage(usr_high_voltage), .usr_ready(usr_ready), .usr_done(usr_done),
        .usr_acked(usr_acked));
    eepwp_device #(.WR_CYCLES(10)) eepwp_device_i (.lnk(eepwp_if_i.dev), .reset(dev_reset),
        .nv_blank(nv_blank), .arr_we(arr_we), .arr_addr(arr_addr), .arr_data(arr_data),
        .permanent_lock_flag(permanent_lock_flag), .reversible_lock_flag(reversible_lock_flag),
        .write_busy(write_busy));
    eepwp_chk eepwp_chk_i (.link_clk(eepwp_if_i.link_clk), .reset(dev_reset),
        .req_tgl(eepwp_if_i.req_tgl), .ctrl_byte(eepwp_if_i.ctrl_byte),
        .word_addr(eepwp_if_i.word_addr), .wdata(eepwp_if_i.wdata),
        .hw_protect(eepwp_if_i.hw_protect), .strap_bit_2(eepwp_if_i.strap_bit_2),
        .strap_bit_1(eepwp_if_i.strap_bit_1), .strap_bit_0(eepwp_if_i.strap_bit_0),
        .high_voltage_level(eepwp_if_i.high_voltage_level), .ack_tgl(eepwp_if_i.ack_tgl),
        .acked(eepwp_if_i.acked));
    // array commits are counted at the link, since the pulse is one link cycle
    always @(posedge eepwp_if_i.link_clk) begin
        if (arr_we === 1'b1) begin
            we_cnt++;
            we_addr = arr_addr;
            we_data = arr_data;
        end
    end
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask
    task automatic send(input eepwp_row_t r);
        int n;
        n = 0;
        while (usr_ready !== 1'b1 && n < 300) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        usr_ctrl = r.ctrl;
        usr_addr = r.addr;
        usr_data = r.data;
        usr_straps = r.straps;
        usr_high_voltage = r.hv;
        usr_protect = r.prot;
        usr_start = 1'b1;
        @(posedge ref_clk);
        #1;
        usr_start = 1'b0;
        n = 0;
        while (usr_done !== 1'b1 && n < 300) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        chk1(usr_done, 1'b1);
    endtask
    task automatic end_of_test();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        #400000;
        miscompares++;
        end_of_test();
    end
    initial begin
        // host released first so the link clock runs during the device reset
        repeat (12) @(posedge ref_clk);
        #1;
        reset = 1'b0;
        repeat (16) @(posedge ref_clk);
        #1;
        dev_reset = 1'b0;
        nv_blank = 1'b0;
        repeat (8) @(posedge ref_clk);
        #1;
        for (int i = 0; i < 22; i++) begin
            cnt0 = we_cnt;
            send(rows[i]);
            chk1(usr_acked, rows[i].exp[3]);
            chk8(8'(we_cnt - cnt0), {7'h00, rows[i].exp[2]});
            if (rows[i].exp[2]) begin
                chk8(we_addr, rows[i].addr);
                chk8(we_data, rows[i].data);
            end
            chk1(permanent_lock_flag, rows[i].exp[1]);
            chk1(reversible_lock_flag, rows[i].exp[0]);
            if (!rows[i].ctrl[0] && rows[i].exp[3]) begin
                chk1(write_busy, 1'b1);
                chk1(usr_ready, 1'b0);
            end
            $display("row %0d done", i);
        end
        // second reset in mid-run: flags must survive it
        dev_reset = 1'b1;
        repeat (16) @(posedge ref_clk);
        #1;
        reset = 1'b1;
        repeat (4) @(posedge ref_clk);
        #1;
        reset = 1'b0;
        repeat (16) @(posedge ref_clk);
        #1;
        dev_reset = 1'b0;
        repeat (8) @(posedge ref_clk);
        #1;
        chk1(permanent_lock_flag, 1'b1);
        chk1(reversible_lock_flag, 1'b1);
        send('{8'h61, 8'h00, 8'h00, 3'h0, 1'h0, 1'h0, 4'h0});
        chk1(usr_acked, 1'b0);
        $display("reset test done");
        end_of_test();
    end
endmodule
